// ### hdl/pptb_time_base.sv
// PWM primary time base, special event, master duty and generator control behind Wishbone
//
// Contract
// - Module enable bit runs the whole PWM; clear holds it disabled; here clear only holds the time base at zero.
// - Idle-halt bit stops the time base while the processor idles.
// - Special event status reads one while a special event is pending.
// - Special event enable lets the pending event raise an interrupt.
// - Immediate period bit loads active period on write; else at boundary.
// - Sync invert bit makes the sync input active low.
// - Sync output enable drives the sync output; clear keeps it low.
// - External sync bit lets the sync input restart the time base.
// - Postscale field issues one trigger per N+1 special events.
// - Period register holds bits 15..3; bits 2..0 read zero.
// - Compare register holds bits 15..3; bits 2..0 read zero.
// - Fault status set by hardware; cleared when fault enable written zero.
// - Current-limit status pending; cleared when its enable written zero.
// - Trigger status pending; cleared when its enable written zero.
// - Fault enable requests interrupts; clear disables and forces status zero.
// - Own-period bit takes generator period from its phase register.
// - Shared-duty bit selects master duty, else the generator duty.
// - Immediate duty bit loads active duty on write; else at boundary.
//
// The Wishbone slave port and the register addresses were left to the implementer.
`include "pptb_params.svh"
`timescale 1ns/1ps
`default_nettype none

module pptb_time_base
    import pptb_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        cpu_idle,
    input  wire logic [6:0]  sync_sources,
    input  wire logic        fault_event,
    input  wire logic        current_limit_event,
    input  wire logic        trigger_event,
    output logic             module_active,
    output logic             sync_output,
    output logic      [15:0] primary_counter,
    output logic             period_boundary,
    output logic             special_event_trigger,
    output logic             special_event_irq,
    output logic             fault_irq,
    output logic             current_limit_irq,
    output logic             trigger_irq,
    output logic      [15:0] gen_period,
    output logic      [15:0] gen_duty
);

    // Byte-lane merge of a write into a 16-bit register
    function automatic pptb_word_t laneMerge(input pptb_word_t old,
                                             input logic [15:0] din,
                                             input logic [1:0] sel);
        laneMerge = {sel[1] ? din[15:8] : old[15:8], sel[0] ? din[7:0] : old[7:0]};
    endfunction

    // Hardware-set, software-cleared status; enable low forces it to zero
    function automatic logic statusNext(input logic old, input logic wbit, input logic wr,
                                        input logic evt, input logic en);
        statusNext = en & (evt | (wr ? (wbit & old) : old));
    endfunction

    pptb_word_t tbcR;
    pptb_word_t periodR;
    pptb_word_t activePeriodR;
    pptb_word_t sevCmpR;
    pptb_word_t mdcR;
    pptb_word_t genCtlR;
    pptb_word_t dutyR;
    pptb_word_t activeDutyR;
    pptb_word_t phaseR;
    pptb_ps_t   pscCntR;
    logic       syncPrevR;
    logic       ackR;
    logic [31:0] rdDataR;

    // Bus decode
    wire logic        wbReq    = wb_cyc_i & wb_stb_i;
    wire logic        wbStart  = wbReq & ~ackR;
    wire logic        wrStb    = wbStart & wb_we_i;
    wire logic [5:0]  wordAdr  = wb_adr_i[7:2];
    wire logic [15:0] wrData   = wb_dat_i[15:0];
    wire logic [1:0]  wrSel    = wb_sel_i[1:0];
    wire logic        wrTbc    = wrStb & (wordAdr == `PPTB_OFS_TBC);
    wire logic        wrPeriod = wrStb & (wordAdr == `PPTB_OFS_PERIOD);
    wire logic        wrSevCmp = wrStb & (wordAdr == `PPTB_OFS_SEVCMP);
    wire logic        wrMdc    = wrStb & (wordAdr == `PPTB_OFS_MDC);
    wire logic        wrGenCtl = wrStb & (wordAdr == `PPTB_OFS_GENCTL);
    wire logic        wrDuty   = wrStb & (wordAdr == `PPTB_OFS_GENDUTY);
    wire logic        wrPhase  = wrStb & (wordAdr == `PPTB_OFS_GENPHASE);

    // Merged write values
    wire pptb_word_t tbcWr    = laneMerge(tbcR, wrData, wrSel) & `PPTB_TBC_MASK;
    wire pptb_word_t periodWr = laneMerge(periodR, wrData, wrSel) & `PPTB_COARSE_MASK;
    wire pptb_word_t sevWr    = laneMerge(sevCmpR, wrData, wrSel) & `PPTB_COARSE_MASK;
    wire pptb_word_t mdcWr    = laneMerge(mdcR, wrData, wrSel);
    wire pptb_word_t gcWr     = laneMerge(genCtlR, wrData, wrSel);
    wire pptb_word_t dutyWr   = laneMerge(dutyR, wrData, wrSel);
    wire pptb_word_t phaseWr  = laneMerge(phaseR, wrData, wrSel) & `PPTB_PHASE_MASK;

    // Control fields
    wire logic      modOn      = tbcR[`PPTB_TBC_ON];
    wire logic      idleHalt   = tbcR[`PPTB_TBC_IDLE];
    wire logic      sevPending = tbcR[`PPTB_TBC_SEVPEND];
    wire logic      sevIrqEn   = tbcR[`PPTB_TBC_SEVIEN];
    wire logic      perNow     = tbcR[`PPTB_TBC_UPDNOW];
    wire logic      syncInv    = tbcR[`PPTB_TBC_INVERT];
    wire logic      syncOutOn  = tbcR[`PPTB_TBC_SYNCOUT];
    wire logic      extSyncOn  = tbcR[`PPTB_TBC_EXTSYNC];
    wire pptb_src_t sync_source_sel    = tbcR[`PPTB_TBC_SRC_LSB +: 3];
    wire pptb_ps_t  postscale  = tbcR[`PPTB_TBC_PS_LSB +: 4];
    wire logic      dutyNow    = genCtlR[`PPTB_GC_DUTYNOW];

    // Time base
    wire logic runEn     = modOn & ~(idleHalt & cpu_idle);
    wire logic srcLevel  = (sync_source_sel == `PPTB_SRC_RESERVED) ? 1'b0
                                                           : sync_sources[sync_source_sel];
    wire logic syncLevel = srcLevel ^ syncInv;
    wire logic syncEdge  = syncLevel & ~syncPrevR;
    wire logic syncHit   = runEn & extSyncOn & syncEdge;
    wire logic atPeriod  = runEn & (primary_counter == activePeriodR);
    wire logic sevEvent  = runEn & (primary_counter == sevCmpR);
    wire logic pscDone   = sevEvent & (pscCntR == postscale);

    // Generator status next values
    wire logic fltEnNew = wrGenCtl ? gcWr[`PPTB_GC_FAULT_IRQ_EN] : genCtlR[`PPTB_GC_FAULT_IRQ_EN];
    wire logic clEnNew  = wrGenCtl ? gcWr[`PPTB_GC_CURRENT_LIMIT_IRQ_EN] : genCtlR[`PPTB_GC_CURRENT_LIMIT_IRQ_EN];
    wire logic trgEnNew = wrGenCtl ? gcWr[`PPTB_GC_TRIGGER_IRQ_EN] : genCtlR[`PPTB_GC_TRIGGER_IRQ_EN];
    wire logic fltStNxt = statusNext(genCtlR[`PPTB_GC_FAULT_PENDING], wrData[`PPTB_GC_FAULT_PENDING],
                                     wrGenCtl & wrSel[1], fault_event, fltEnNew);
    wire logic clStNxt  = statusNext(genCtlR[`PPTB_GC_CURRENT_LIMIT_PENDING], wrData[`PPTB_GC_CURRENT_LIMIT_PENDING],
                                     wrGenCtl & wrSel[1], current_limit_event, clEnNew);
    wire logic trgStNxt = statusNext(genCtlR[`PPTB_GC_TRIGGER_PENDING], wrData[`PPTB_GC_TRIGGER_PENDING],
                                     wrGenCtl & wrSel[1], trigger_event, trgEnNew);
    wire pptb_word_t gcBase = wrGenCtl ? (gcWr & `PPTB_GC_MASK) : (genCtlR & `PPTB_GC_MASK);
    wire pptb_word_t gcNxt  = gcBase | {fltStNxt, clStNxt, trgStNxt, 13'h0000};

    // Special event pending: a new event wins over a software clear
    wire logic sevPendBase = wrTbc ? tbcWr[`PPTB_TBC_SEVPEND] : sevPending;
    wire pptb_word_t tbcBase = wrTbc ? tbcWr : tbcR;
    wire logic sevPendNxt  = sevEvent | sevPendBase;

    // Read mux
    wire logic [15:0] rdWord =
        (wordAdr == `PPTB_OFS_TBC)      ? tbcR :
        (wordAdr == `PPTB_OFS_PERIOD)   ? periodR :
        (wordAdr == `PPTB_OFS_SEVCMP)   ? sevCmpR :
        (wordAdr == `PPTB_OFS_MDC)      ? mdcR :
        (wordAdr == `PPTB_OFS_GENCTL)   ? genCtlR :
        (wordAdr == `PPTB_OFS_GENDUTY)  ? dutyR :
        (wordAdr == `PPTB_OFS_GENPHASE) ? phaseR : 16'h0000;

    // Bus answer: one registered wait state, unmapped reads give zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ackR    <= 1'b0;
            rdDataR <= 32'h0000_0000;
        end else begin
            ackR    <= wbStart;
            rdDataR <= {16'h0000, rdWord};
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tbcR    <= `PPTB_RESET_WORD;
            periodR <= `PPTB_RESET_WORD;
            sevCmpR <= `PPTB_RESET_WORD;
            mdcR    <= `PPTB_RESET_WORD;
            genCtlR <= `PPTB_RESET_WORD;
            dutyR   <= `PPTB_RESET_WORD;
            phaseR  <= `PPTB_RESET_WORD;
        end else begin
            tbcR    <= {tbcBase[15:13], sevPendNxt, tbcBase[11:0]};
            genCtlR <= gcNxt;
            if (wrPeriod) periodR <= periodWr;
            if (wrSevCmp) sevCmpR <= sevWr;
            if (wrMdc) mdcR <= mdcWr;
            if (wrDuty) dutyR <= dutyWr;
            if (wrPhase) phaseR <= phaseWr;
        end
    end

    // Active period and duty shadows
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            activePeriodR <= `PPTB_RESET_WORD;
            activeDutyR   <= `PPTB_RESET_WORD;
        end else begin
            if (wrPeriod && perNow) begin
                activePeriodR <= periodWr;
            end else if (atPeriod) begin
                activePeriodR <= periodR;
            end
            if (wrDuty && dutyNow) begin
                activeDutyR <= dutyWr;
            end else if (atPeriod) begin
                activeDutyR <= dutyR;
            end
        end
    end

    // Counter, sync and postscaler
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            primary_counter       <= 16'h0000;
            syncPrevR             <= 1'b0;
            pscCntR               <= 4'h0;
            period_boundary       <= 1'b0;
            sync_output           <= 1'b0;
            special_event_trigger <= 1'b0;
        end else begin
            syncPrevR             <= syncLevel;
            period_boundary       <= atPeriod;
            sync_output           <= atPeriod & syncOutOn;
            special_event_trigger <= pscDone;
            if (!modOn) begin
                primary_counter <= 16'h0000;
                pscCntR         <= 4'h0;
            end else begin
                if (syncHit || atPeriod) begin
                    primary_counter <= 16'h0000;
                end else if (runEn) begin
                    primary_counter <= primary_counter + 16'h0001;
                end
                if (pscDone) begin
                    pscCntR <= 4'h0;
                end else if (sevEvent) begin
                    pscCntR <= pscCntR + 4'h1;
                end
            end
        end
    end

    // Generator period and duty selection
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gen_period <= 16'h0000;
            gen_duty   <= 16'h0000;
        end else begin
            gen_period <= genCtlR[`PPTB_GC_OWNPER] ? phaseR : activePeriodR;
            gen_duty   <= genCtlR[`PPTB_GC_SHDUTY] ? mdcR : activeDutyR;
        end
    end

    assign wb_ack_o          = ackR;
    assign wb_dat_o          = rdDataR;
    assign module_active     = modOn;
    assign special_event_irq = sevPending & sevIrqEn;
    assign fault_irq         = genCtlR[`PPTB_GC_FAULT_PENDING] & genCtlR[`PPTB_GC_FAULT_IRQ_EN];
    assign current_limit_irq = genCtlR[`PPTB_GC_CURRENT_LIMIT_PENDING] & genCtlR[`PPTB_GC_CURRENT_LIMIT_IRQ_EN];
    assign trigger_irq       = genCtlR[`PPTB_GC_TRIGGER_PENDING] & genCtlR[`PPTB_GC_TRIGGER_IRQ_EN];

    module_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !modOn |=> (primary_counter == 16'h0000))
        else $error("counter not held at zero while module disabled");

    idle_halt_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (modOn && idleHalt && cpu_idle && !wrTbc) |=> $stable(primary_counter))
        else $error("time base moved while halted in idle");

    sev_pending_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        sevEvent |=> sevPending)
        else $error("special event did not set pending status");

    sev_irq_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (sevEvent && sevIrqEn && !wrTbc) |=> special_event_irq)
        else $error("enabled special event raised no interrupt");

    period_now_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wrPeriod && perNow) |=> (activePeriodR == $past(periodWr)))
        else $error("immediate period update not applied");

    period_defer_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!perNow && !atPeriod && !wrPeriod) |=> $stable(activePeriodR))
        else $error("deferred period changed off boundary");

    sync_restart_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        syncHit |=> (primary_counter == 16'h0000))
        else $error("external sync did not restart time base");

    sync_out_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        sync_output |-> ($past(atPeriod) && $past(syncOutOn)))
        else $error("sync output without enabled boundary");

    postscale_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        special_event_trigger |-> $past(sevEvent) && ($past(pscCntR) == $past(postscale)))
        else $error("postscaled trigger at wrong event count");

    low_bits_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (periodR[2:0] == 3'h0) && (sevCmpR[2:0] == 3'h0))
        else $error("unimplemented low period or compare bits set");

    fault_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !genCtlR[`PPTB_GC_FAULT_IRQ_EN] |-> !genCtlR[`PPTB_GC_FAULT_PENDING])
        else $error("fault status set while fault interrupt disabled");

    cl_trg_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wrGenCtl && wrSel[1] && !gcWr[`PPTB_GC_CURRENT_LIMIT_IRQ_EN] && !gcWr[`PPTB_GC_TRIGGER_IRQ_EN])
        |=> !genCtlR[`PPTB_GC_CURRENT_LIMIT_PENDING] && !genCtlR[`PPTB_GC_TRIGGER_PENDING])
        else $error("limit or trigger status survived enable clear");

    counter_wrap_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (atPeriod && modOn) |=> (primary_counter == 16'h0000) && period_boundary)
        else $error("counter did not wrap at period");

    duty_select_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        genCtlR[`PPTB_GC_SHDUTY] |=> (gen_duty == $past(mdcR)))
        else $error("generator duty not taken from master duty");

    sync_invert_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (runEn && extSyncOn && syncInv && $stable(syncInv) && $fell(srcLevel))
        |=> (primary_counter == 16'h0000))
        else $error("inverted sync input did not restart time base");

    sync_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !syncOutOn |=> !sync_output)
        else $error("sync output pulsed while disabled");

    ext_sync_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (runEn && !extSyncOn && !atPeriod) |=> (primary_counter == $past(primary_counter) + 16'h0001))
        else $error("time base disturbed with external sync off");

    trg_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wrGenCtl && wrSel[1] && !gcWr[`PPTB_GC_TRIGGER_IRQ_EN]) |=> !genCtlR[`PPTB_GC_TRIGGER_PENDING])
        else $error("trigger status survived enable clear");

    fault_irq_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (fault_event && genCtlR[`PPTB_GC_FAULT_IRQ_EN] && !wrGenCtl) |=> fault_irq)
        else $error("enabled fault raised no interrupt");

    own_period_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        genCtlR[`PPTB_GC_OWNPER] |=> (gen_period == $past(phaseR)))
        else $error("generator period not taken from phase register");

    duty_now_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wrDuty && dutyNow) |=> (activeDutyR == $past(dutyWr)))
        else $error("immediate duty update not applied");

endmodule

`default_nettype wire

// ### hdl/pptb_params.svh
// Register offsets, field positions, masks and reset values of the PWM time base block
`ifndef PPTB_PARAMS_SVH
`define PPTB_PARAMS_SVH

`define PPTB_OFS_TBC        6'h00
`define PPTB_OFS_PERIOD     6'h01
`define PPTB_OFS_SEVCMP     6'h02
`define PPTB_OFS_MDC        6'h03
`define PPTB_OFS_GENCTL     6'h04
`define PPTB_OFS_GENDUTY    6'h05
`define PPTB_OFS_GENPHASE   6'h06

`define PPTB_TBC_ON         15
`define PPTB_TBC_IDLE       13
`define PPTB_TBC_SEVPEND    12
`define PPTB_TBC_SEVIEN     11
`define PPTB_TBC_UPDNOW     10
`define PPTB_TBC_INVERT     9
`define PPTB_TBC_SYNCOUT    8
`define PPTB_TBC_EXTSYNC    7
`define PPTB_TBC_SRC_LSB    4
`define PPTB_TBC_PS_LSB     0
`define PPTB_TBC_MASK       16'hBFFF

`define PPTB_GC_FAULT_PENDING     15
`define PPTB_GC_CURRENT_LIMIT_PENDING      14
`define PPTB_GC_TRIGGER_PENDING     13
`define PPTB_GC_FAULT_IRQ_EN      12
`define PPTB_GC_CURRENT_LIMIT_IRQ_EN       11
`define PPTB_GC_TRIGGER_IRQ_EN      10
`define PPTB_GC_OWNPER      9
`define PPTB_GC_SHDUTY      8
`define PPTB_GC_DUTYNOW     0
`define PPTB_GC_MASK        16'h1FC3

`define PPTB_COARSE_MASK    16'hFFF8
`define PPTB_PHASE_MASK     16'hFFFC
`define PPTB_SRC_RESERVED   3'h7
`define PPTB_RESET_WORD     16'h0000

`endif

// ### hdl/pptb_pkg.sv
// Shared types of the PWM time base block
`default_nettype none
package pptb_pkg;
    typedef logic [15:0] pptb_word_t;
    typedef logic [3:0]  pptb_ps_t;
    typedef logic [2:0]  pptb_src_t;
endpackage
`default_nettype wire

// ### verification/test_power_pwm_time_base_control.sv
// Self-checking testbench of the PWM time base block driven over Wishbone
`include "pptb_params.svh"
`timescale 1ns/1ps
`default_nettype none

module test_power_pwm_time_base_control
    import pptb_pkg::*;
();
    localparam pptb_word_t ON  = 16'h8000;
    localparam pptb_word_t NOW = 16'h0400;
    localparam pptb_word_t MASKS [8] = '{`PPTB_TBC_MASK, `PPTB_COARSE_MASK, `PPTB_COARSE_MASK,
        16'hFFFF, `PPTB_GC_MASK, 16'hFFFF, `PPTB_PHASE_MASK, 16'h0000};

    logic        core_clk = 1'h0;
    logic        rst_n    = 1'h0;
    logic        wbCyc    = 1'h0;
    logic        wbStb    = 1'h0;
    logic        wbWe     = 1'h0;
    logic [7:0]  wbAdr    = 8'h00;
    logic [3:0]  wbSel    = 4'h0;
    logic [31:0] wbDatI   = 32'h0000_0000;
    logic        cpuIdle  = 1'h0;
    logic [6:0]  sync_source_sel  = 7'h00;
    logic [2:0]  evt      = 3'h0;
    logic [31:0] wbDatO;
    logic        wbAck;
    logic        moduleActive;
    logic        syncOut;
    logic        periodBoundary;
    logic        sevTrigger;
    logic        sevIrq;
    logic [2:0]  genIrq;
    logic [15:0] counter;
    logic [15:0] genPeriod;
    logic [15:0] genDuty;
    int          fail_count = 0;
    int          n_checks = 0;
    int          n;
    int          m;
    pptb_word_t  rd;

    always #20 core_clk = ~core_clk;

    pptb_time_base dut (
        .core_clk              (core_clk),
        .rst_n                 (rst_n),
        .wb_cyc_i              (wbCyc),
        .wb_stb_i              (wbStb),
        .wb_we_i               (wbWe),
        .wb_adr_i              (wbAdr),
        .wb_sel_i              (wbSel),
        .wb_dat_i              (wbDatI),
        .wb_dat_o              (wbDatO),
        .wb_ack_o              (wbAck),
        .cpu_idle              (cpuIdle),
        .sync_sources          (sync_source_sel),
        .fault_event           (evt[0]),
        .current_limit_event   (evt[1]),
        .trigger_event         (evt[2]),
        .module_active         (moduleActive),
        .sync_output           (syncOut),
        .primary_counter       (counter),
        .period_boundary       (periodBoundary),
        .special_event_trigger (sevTrigger),
        .special_event_irq     (sevIrq),
        .fault_irq             (genIrq[0]),
        .current_limit_irq     (genIrq[1]),
        .trigger_irq           (genIrq[2]),
        .gen_period            (genPeriod),
        .gen_duty              (genDuty)
    );

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Classic single cycle: hold everything until ack is sampled high
    task automatic bus(input logic we, input logic [5:0] idx, input pptb_word_t wd,
                       output pptb_word_t rdv);
        int k;
        @(posedge core_clk);
        wbCyc <= 1'h1;
        wbStb <= 1'h1;
        wbWe <= we;
        wbAdr <= {idx, 2'h0};
        wbSel <= 4'h3;
        wbDatI <= {16'h0000, wd};
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (wbAck !== 1'h1 && k < 16);
        check("bus ack", 16'h0001, {15'h0000, wbAck});
        if (wbAck !== 1'h1) conclude();
        rdv = wbDatO[15:0];
        wbCyc <= 1'h0;
        wbStb <= 1'h0;
        wbWe <= 1'h0;
    endtask

    task automatic wr(input logic [5:0] idx, input pptb_word_t wd);
        pptb_word_t dummy;
        bus(1'h1, idx, wd, dummy);
    endtask

    task automatic rdchk(input string what, input logic [5:0] idx, input pptb_word_t exp);
        pptb_word_t v;
        bus(1'h0, idx, 16'h0000, v);
        check(what, exp, v);
    endtask

    // Returns the number of edges until the pulse is seen; a miss ends the run
    task automatic waitFor(ref logic s, input int lim, output int cnt);
        cnt = 0;
        do begin
            @(posedge core_clk);
            cnt++;
        end while (s !== 1'h1 && cnt < lim);
        if (s !== 1'h1) begin
            fail_count++;
            $display("ERROR pulse wait expected 1 seen %b", s);
            conclude();
        end
    endtask

    task automatic clocks(input int c);
        repeat (c) @(posedge core_clk);
    endtask

    task automatic pulseEvt(input int i);
        @(posedge core_clk);
        evt <= 3'h1 << i;
        @(posedge core_clk);
        evt <= 3'h0;
    endtask

    task automatic syncTry(input pptb_word_t tbc, input logic [6:0] lvl, input pptb_word_t exp);
        wr(`PPTB_OFS_TBC, tbc);
        waitFor(periodBoundary, 40, n);
        clocks(4);
        @(posedge core_clk);
        sync_source_sel <= lvl;
        clocks(2);
        check("counter after sync edge", exp, counter);
    endtask

    initial begin
        clocks(10);
        rst_n <= 1'h1;
        check("module active at reset", 16'h0000, {15'h0000, moduleActive});
        for (int i = 0; i < 8; i++) begin
            rdchk("reset value", i[5:0], 16'h0000);
            wr(i[5:0], 16'hFFFF);
            rdchk("masked readback", i[5:0], MASKS[i]);
            if (i == 0) check("event irq", 16'h0001, {15'h0000, sevIrq});
            wr(i[5:0], 16'h0000);
        end
        wr(`PPTB_OFS_TBC, 16'h1000);
        check("event irq masked", 16'h0000, {15'h0000, sevIrq});
        rdchk("pending written", `PPTB_OFS_TBC, 16'h1000);
        wr(`PPTB_OFS_TBC, ON | NOW);
        wr(`PPTB_OFS_PERIOD, 16'h0010);
        check("module active", 16'h0001, {15'h0000, moduleActive});
        waitFor(periodBoundary, 40, n);
        check("counter at wrap", 16'h0000, counter);
        waitFor(periodBoundary, 40, n);
        check("period length", 16'd17, n[15:0]);
        wr(`PPTB_OFS_TBC, ON);
        waitFor(periodBoundary, 40, n);
        wr(`PPTB_OFS_PERIOD, 16'h0020);
        check("deferred period", 16'h0010, genPeriod);
        waitFor(periodBoundary, 40, n);
        waitFor(periodBoundary, 40, n);
        check("new period length", 16'd33, n[15:0]);
        wr(`PPTB_OFS_TBC, ON | NOW);
        wr(`PPTB_OFS_PERIOD, 16'h0010);
        clocks(2);
        check("immediate period", 16'h0010, genPeriod);
        wr(`PPTB_OFS_GENPHASE, 16'h0044);
        wr(`PPTB_OFS_GENCTL, 16'h0200);
        clocks(2);
        check("own period", 16'h0044, genPeriod);
        wr(`PPTB_OFS_MDC, 16'h0100);
        wr(`PPTB_OFS_GENCTL, 16'h0101);
        wr(`PPTB_OFS_GENDUTY, 16'h0200);
        clocks(2);
        check("shared duty", 16'h0100, genDuty);
        wr(`PPTB_OFS_GENCTL, 16'h0001);
        clocks(2);
        check("own duty", 16'h0200, genDuty);
        wr(`PPTB_OFS_GENCTL, 16'h0000);
        waitFor(periodBoundary, 40, n);
        wr(`PPTB_OFS_GENDUTY, 16'h0300);
        check("deferred duty", 16'h0200, genDuty);
        waitFor(periodBoundary, 40, n);
        clocks(2);
        check("duty at boundary", 16'h0300, genDuty);
        @(posedge core_clk);
        cpuIdle <= 1'h1;
        wr(`PPTB_OFS_TBC, ON | NOW | 16'h2000);
        rd = counter;
        clocks(5);
        check("halted in idle", rd, counter);
        wr(`PPTB_OFS_TBC, ON | NOW);
        rd = counter;
        clocks(5);
        check("running in idle", 16'((rd + 16'd5) % 16'd17), counter);
        @(posedge core_clk);
        cpuIdle <= 1'h0;
        wr(`PPTB_OFS_SEVCMP, 16'h0008);
        for (int ps = 0; ps < 16; ps++) begin
            wr(`PPTB_OFS_TBC, ON | NOW | 16'(ps));
            waitFor(sevTrigger, 310, n);
            check("counter at trigger", 16'h0009, counter);
            waitFor(sevTrigger, 310, n);
            check("postscale interval", 16'(17 * (ps + 1)), n[15:0]);
        end
        rdchk("event pending", `PPTB_OFS_TBC, ON | NOW | 16'h100F);
        for (int s = 0; s < 2; s++) begin
            wr(`PPTB_OFS_TBC, ON | NOW | (s == 0 ? 16'h0100 : 16'h0000));
            m = 0;
            for (int k = 0; k < 34; k++) begin
                @(posedge core_clk);
                m += (syncOut === 1'h1);
            end
            check("sync out pulses", 16'(2 - 2 * s), m[15:0]);
        end
        syncTry(ON | NOW | 16'h00A0, 7'h04, 16'h0000);
        syncTry(ON | NOW | 16'h02A0, 7'h00, 16'h0000);
        syncTry(ON | NOW | 16'h0020, 7'h04, 16'h0007);
        for (int i = 0; i < 3; i++) begin
            wr(`PPTB_OFS_GENCTL, 16'h1C00);
            pulseEvt(i);
            rdchk("status set", `PPTB_OFS_GENCTL, 16'h1C00 | (16'h8000 >> i));
            check("generator irq", 16'h0001 << i, {13'h0000, genIrq});
            wr(`PPTB_OFS_GENCTL, 16'h1C00);
            rdchk("status acked", `PPTB_OFS_GENCTL, 16'h1C00);
            pulseEvt(i);
            rd = 16'h1C00 & ~(16'h1000 >> i);
            wr(`PPTB_OFS_GENCTL, rd);
            rdchk("status cleared", `PPTB_OFS_GENCTL, rd);
            pulseEvt(i);
            rdchk("status held off", `PPTB_OFS_GENCTL, rd);
            check("irq off", 16'h0000, {13'h0000, genIrq});
        end
        conclude();
    end
endmodule

`default_nettype wire
